/* core/port_e_gpio_mux.sv */
// port e gpio with external bus, slave port and pwm pin sharing
//
// Chosen here: the address-and-strobe port and the register addresses.
`include "port_e_defines.svh"

module port_e_gpio_mux
  import port_e_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      rst_b,
  // register port
  input  wire reg_addr_t reg_addr,
  input  wire byte_t     reg_wdata,
  input  wire logic      reg_wr,
  input  wire logic      reg_rd,
  output      byte_t     reg_rdata,
  // package straps and configuration bits, static after power-up
  input  wire logic      pkg_small,
  input  wire logic      pkg_largest,
  input  wire logic      mcu_mode,
  input  wire logic      pwm_bc_pin_select,
  input  wire logic      pwm2_alt_pin_select,
  // external memory bus, high address/data byte
  input  wire byte_t     ext_bus_out,
  input  wire logic      ext_bus_oe,
  output      byte_t     ext_bus_in,
  // enhanced pwm outputs
  input  wire logic      pwm1_out_b,
  input  wire logic      pwm1_out_c,
  input  wire logic      pwm3_out_b,
  input  wire logic      pwm3_out_c,
  input  wire logic      pwm2_out_a,
  input  wire logic      pwm2_out_b,
  input  wire logic      pwm2_out_c,
  input  wire logic      pwm2_out_d,
  input  wire logic      pwm1_enable,
  input  wire logic      pwm2_enable,
  input  wire logic      pwm3_enable,
  input  wire logic      pwm_shutdown,
  // slave port control strobes, active low at the pins
  output      logic      slave_rd_b,
  output      logic      slave_wr_b,
  output      logic      slave_cs_b,
  output      logic      slave_port_mode_bit,
  // port d pull-up enable, handed to the port d block
  output      logic      port_d_pullup_enable,
  // pwm 1/3 b/c outputs rerouted away from this port
  output      logic      pwm_bc_to_port_h,
  // pads
  input  wire byte_t     pad_in,
  output      byte_t     pad_out,
  output      byte_t     pad_oe,
  output      byte_t     pad_pullup
);

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  byte_t pin_sync1;
  byte_t pin_sync2;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_sync1 <= 8'h00;
      pin_sync2 <= 8'h00;
    end else begin
      pin_sync1 <= pad_in;
      pin_sync2 <= pin_sync1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  byte_t port_e_direction;
  byte_t port_e_latch;
  byte_t port_a_latch_register;
  byte_t memory_interface_control;
  byte_t slave_port_control;
  byte_t pwm_control;
  byte_t next_port_e_direction;
  byte_t next_port_e_latch;
  byte_t next_port_a_latch_register;
  byte_t next_memory_interface_control;
  byte_t next_slave_port_control;
  byte_t next_pwm_control;
  byte_t next_reg_rdata;
  byte_t impl_mask;

  // small package has pins 5:0 only; missing bits read as zero
  assign impl_mask = pkg_small ? 8'h3F : 8'hFF;

  always_comb begin
    next_port_e_direction         = port_e_direction;
    next_port_e_latch             = port_e_latch;
    next_port_a_latch_register    = port_a_latch_register;
    next_memory_interface_control = memory_interface_control;
    next_slave_port_control       = slave_port_control;
    next_pwm_control              = pwm_control;
    next_reg_rdata                = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        `ADDR_PORT_E_DIRECTION:   next_port_e_direction = reg_wdata;
        // writes to the pin-level address land in the latch
        `ADDR_PORT_E_LATCH,
        `ADDR_PORT_E_PIN_LEVELS:  next_port_e_latch = reg_wdata;
        `ADDR_PORT_A_LATCH:       next_port_a_latch_register = reg_wdata;
        `ADDR_MEMORY_IF_CONTROL:  next_memory_interface_control = reg_wdata;
        `ADDR_SLAVE_PORT_CONTROL: next_slave_port_control = reg_wdata;
        `ADDR_PWM_CONTROL:        next_pwm_control = reg_wdata;
        default:                  next_port_e_latch = port_e_latch;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `ADDR_PORT_E_DIRECTION:
          next_reg_rdata = port_e_direction & impl_mask;
        `ADDR_PORT_E_LATCH:
          next_reg_rdata = port_e_latch & impl_mask;
        `ADDR_PORT_E_PIN_LEVELS:
          next_reg_rdata = pin_sync2 & impl_mask;
        `ADDR_PORT_A_LATCH:       next_reg_rdata = port_a_latch_register;
        `ADDR_MEMORY_IF_CONTROL:  next_reg_rdata = memory_interface_control;
        `ADDR_SLAVE_PORT_CONTROL: next_reg_rdata = slave_port_control;
        `ADDR_PWM_CONTROL:        next_reg_rdata = pwm_control;
        default:                  next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_e_direction         <= `RST_DIRECTION;
      port_e_latch             <= `RST_LATCH;
      port_a_latch_register    <= `RST_PORT_A_LATCH;
      memory_interface_control <= `RST_MEMORY_IF_CONTROL;
      slave_port_control       <= `RST_SLAVE_PORT_CONTROL;
      pwm_control              <= `RST_PWM_CONTROL;
      reg_rdata                <= 8'h00;
    end else begin
      port_e_direction         <= next_port_e_direction;
      port_e_latch             <= next_port_e_latch;
      port_a_latch_register    <= next_port_a_latch_register;
      memory_interface_control <= next_memory_interface_control;
      slave_port_control       <= next_slave_port_control;
      pwm_control              <= next_pwm_control;
      reg_rdata                <= next_reg_rdata;
    end
  end

  // ----------------------------------------------------------------
  // pin function resolution
  // ----------------------------------------------------------------
  logic  ext_bus_active;
  logic  slave_mode;
  logic  pullup_global;
  logic  float_on_shutdown;
  byte_t pwm_en;
  byte_t pwm_val;
  byte_t next_pad_out;
  byte_t next_pad_oe;
  byte_t next_pad_pullup;
  byte_t next_ext_bus_in;

  // the bus only exists on the largest package
  assign ext_bus_active = pkg_largest &&
    !memory_interface_control[`BIT_EXT_BUS_DISABLE];
  assign slave_mode = slave_port_control[`BIT_SLAVE_PORT_MODE];
  assign pullup_global =
    port_a_latch_register[`BIT_PORT_E_PULLUP_ENABLE];
  assign float_on_shutdown = pwm_control[`BIT_PWM_SHUTDOWN_FLOAT];

  // default pwm placement; pin 6 and 7 only exist on larger packages
  always_comb begin
    pwm_en  = 8'h00;
    pwm_val = 8'h00;
    pwm_en[0]  = pwm2_enable;
    pwm_val[0] = pwm2_out_d;
    pwm_en[1]  = pwm2_enable;
    pwm_val[1] = pwm2_out_c;
    pwm_en[2]  = pwm2_enable;
    pwm_val[2] = pwm2_out_b;
    if (pkg_small || pwm_bc_pin_select) begin
      pwm_en[3]  = pwm3_enable;
      pwm_val[3] = pwm3_out_c;
      pwm_en[4]  = pwm3_enable;
      pwm_val[4] = pwm3_out_b;
      pwm_en[5]  = pwm1_enable;
      pwm_val[5] = pwm1_out_c;
      // on the small package pwm1 b lives on port d pin 0
      pwm_en[6]  = pwm1_enable && !pkg_small;
      pwm_val[6] = pwm1_out_b;
    end
    if (!pkg_small && mcu_mode && !pwm2_alt_pin_select) begin
      pwm_en[7]  = pwm2_enable;
      pwm_val[7] = pwm2_out_a;
    end
  end

  always_comb begin
    next_pad_out    = 8'h00;
    next_pad_oe     = 8'h00;
    next_pad_pullup = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (ext_bus_active) begin
        next_pad_out[i] = ext_bus_out[i];
        next_pad_oe[i]  = ext_bus_oe;
      end else if (pwm_en[i]) begin
        next_pad_out[i] = pwm_val[i];
        next_pad_oe[i]  = !(pwm_shutdown && float_on_shutdown);
      end else if (slave_mode && i < 3) begin
        // strobes are inputs regardless of the direction bit
        next_pad_oe[i] = 1'b0;
      end else begin
        next_pad_out[i] = port_e_latch[i];
        next_pad_oe[i]  = !port_e_direction[i];
      end
      // pull-up only on a pin nobody drives and never on an output
      next_pad_pullup[i] = pullup_global && !ext_bus_active &&
        port_e_direction[i] && !next_pad_oe[i];
    end
    next_pad_out    = next_pad_out & impl_mask;
    next_pad_oe     = next_pad_oe & impl_mask;
    next_pad_pullup = next_pad_pullup & impl_mask;
    next_ext_bus_in = ext_bus_active ? pin_sync2 : 8'h00;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pad_out              <= 8'h00;
      pad_oe               <= 8'h00;
      pad_pullup           <= 8'h00;
      ext_bus_in           <= 8'h00;
      slave_rd_b           <= 1'b1;
      slave_wr_b           <= 1'b1;
      slave_cs_b           <= 1'b1;
      slave_port_mode_bit  <= 1'b0;
      port_d_pullup_enable <= 1'b0;
      pwm_bc_to_port_h     <= 1'b0;
    end else begin
      pad_out    <= next_pad_out;
      pad_oe     <= next_pad_oe;
      pad_pullup <= next_pad_pullup;
      ext_bus_in <= next_ext_bus_in;
      // strobes idle high whenever slave mode is off or the bus owns pins
      slave_rd_b <= !(slave_mode && !ext_bus_active) ||
                    pin_sync2[0];
      slave_wr_b <= !(slave_mode && !ext_bus_active) || pin_sync2[1];
      slave_cs_b <= !(slave_mode && !ext_bus_active && pkg_largest) ||
                    pin_sync2[2];
      slave_port_mode_bit  <= slave_mode;
      port_d_pullup_enable <=
        port_a_latch_register[`BIT_PORT_D_PULLUP_ENABLE];
      pwm_bc_to_port_h <= !pkg_small && !pwm_bc_pin_select;
    end
  end

endmodule : port_e_gpio_mux

/* include/port_e_defines.svh */
// constants for the port e pin multiplexer
`ifndef PORT_E_DEFINES_SVH
`define PORT_E_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_PORT_E_DIRECTION    4'h0
`define ADDR_PORT_E_LATCH        4'h1
`define ADDR_PORT_E_PIN_LEVELS   4'h2
`define ADDR_PORT_A_LATCH        4'h3
`define ADDR_MEMORY_IF_CONTROL   4'h4
`define ADDR_SLAVE_PORT_CONTROL  4'h5
`define ADDR_PWM_CONTROL         4'h6

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_PORT_E_PULLUP_ENABLE 6
`define BIT_PORT_D_PULLUP_ENABLE 7
`define BIT_EXT_BUS_DISABLE      7
`define BIT_SLAVE_PORT_MODE      4
`define BIT_PWM_SHUTDOWN_FLOAT   0
`define BIT_PKG_SMALL            0
`define BIT_PKG_LARGEST          1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_DIRECTION            8'hFF
`define RST_LATCH                8'h00
`define RST_PORT_A_LATCH         8'h00
`define RST_MEMORY_IF_CONTROL    8'h00
`define RST_SLAVE_PORT_CONTROL   8'h00
`define RST_PWM_CONTROL          8'h00

`endif

/* include/port_e_pkg.sv */
// types shared by the port e pin multiplexer
package port_e_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] reg_addr_t;
endpackage : port_e_pkg

/* verification/pad_model.sv */
// board model of the port e pads: drivers, pull-ups and floating pins
module pad_model
  import port_e_pkg::*;
(
  input  logic  core_clk,
  input  byte_t pad_out,
  input  byte_t pad_oe,
  input  byte_t pad_pullup,
  input  byte_t drv_en,
  input  byte_t drv_val,
  output byte_t pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // a floating pin wanders every cycle so a stale level is never trusted
  logic wander = 1'b0;
  always @(posedge core_clk) wander <= !wander;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : drv_en[i] ? drv_val[i]
                : pad_pullup[i] ? 1'b1 : wander ^ i[0];
    end
  end
endmodule : pad_model

/* verification/port_e_gpio_mux_props.sv */
// assertion checker for the port e pin multiplexer
module port_e_gpio_mux_props
  import port_e_pkg::*;
(
  input logic      core_clk,
  input logic      rst_b,
  input reg_addr_t reg_addr,
  input byte_t     reg_wdata,
  input logic      reg_wr,
  input logic      reg_rd,
  input byte_t     reg_rdata,
  input logic      pkg_small,
  input logic      pkg_largest,
  input byte_t     ext_bus_out,
  input logic      ext_bus_oe,
  input logic      pwm2_out_d,
  input logic      pwm1_enable,
  input logic      pwm2_enable,
  input logic      pwm3_enable,
  input logic      pwm_shutdown,
  input logic      slave_rd_b,
  input logic      slave_wr_b,
  input logic      slave_cs_b,
  input byte_t     pad_in,
  input byte_t     pad_out,
  input byte_t     pad_oe,
  input byte_t     pad_pullup
);
  timeunit 1ns;
  timeprecision 1ps;
  // register shadow built from the write port, so pads can be predicted
  byte_t sh [7];
  byte_t msk;
  logic  bo;
  logic  plain;
  assign msk = pkg_small ? 8'h3F : 8'hFF;
  assign bo = sh[4][7] || !pkg_largest;
  assign plain = bo && !sh[5][4]
               && !(pwm1_enable | pwm2_enable | pwm3_enable);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 7; i++) begin
        sh[i] <= (i == 0) ? 8'hFF : 8'h00;
      end
    end else if (reg_wr && reg_addr < 4'h7) begin
      sh[(reg_addr == 4'h2) ? 3'h1 : reg_addr[2:0]] <= reg_wdata;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_reset_pads_off: assert property (
    $rose(rst_b) |-> pad_oe == 8'h00 && pad_pullup == 8'h00)
    else $error("pads active at reset release");
  a_latch_readback: assert property (
    $past(reg_rd && reg_addr == 4'h1) |-> reg_rdata == ($past(sh[1]) & msk))
    else $error("latch read wrong");
  a_dir_drive: assert property (
    $past(rst_b && plain) |-> pad_oe == (~$past(sh[0]) & msk))
    else $error("pad enable not direction");
  a_latch_drive: assert property (
    $past(rst_b && plain) |-> (pad_out & pad_oe) == ($past(sh[1]) & pad_oe))
    else $error("pad data not latch");
  a_bus_owns_pins: assert property (
    $past(rst_b && !bo && ext_bus_oe)
    |-> pad_oe == 8'hFF && pad_out == $past(ext_bus_out))
    else $error("bus does not own pins");
  a_pullup_rule: assert property (
    $past(rst_b && plain)
    |-> pad_pullup == ($past(sh[0] & {8{sh[3][6]}}) & msk))
    else $error("pull-up wrong");
  a_pwm_wins: assert property (
    $past(rst_b && bo && pwm2_enable && !pwm_shutdown)
    |-> pad_oe[0] && pad_out[0] == $past(pwm2_out_d))
    else $error("pwm not on pin 0");
  a_slave_strobes: assert property (
    (bo && sh[5][4] && $stable(pad_in[2:0])) [*4]
    |-> {slave_cs_b, slave_wr_b, slave_rd_b}
        == {pad_in[2] | !pkg_largest, pad_in[1:0]})
    else $error("slave strobe wrong");
endmodule : port_e_gpio_mux_props

bind port_e_gpio_mux port_e_gpio_mux_props port_e_gpio_mux_props_i (.*);

/* verification/tb_top.sv */
// self-checking bench for the port e pin multiplexer
module tb_top
  import port_e_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic      core_clk = 1'b0;
  logic      rst_b = 1'b0;
  reg_addr_t reg_addr = 4'h0;
  byte_t     reg_wdata = 8'h00;
  logic      reg_wr = 1'b0;
  logic      reg_rd = 1'b0;
  byte_t     ext_bus_out = 8'h00;
  logic      ext_bus_oe = 1'b0;
  byte_t     pwm_v = 8'h00;
  logic [3:0] pwm_ctl = 4'h0;
  byte_t     drv_en = 8'h00;
  byte_t     drv_val = 8'h00;
  logic      small_pkg = 1'b0;
  logic      large_pkg = 1'b1;
  logic      bc_sel = 1'b1;
  logic      slave_port_mode_bit, port_d_pullup_enable, pwm_bc_to_port_h;
  byte_t     reg_rdata, ext_bus_in, pad_in, pad_out, pad_oe, pad_pullup;
  logic      slave_rd_b, slave_wr_b, slave_cs_b;
  byte_t     exp_q [$];
  logic      rd_seen = 1'b0;
  int        errors = 0;
  int        checks = 0;
  byte_t     d, v;

  port_e_gpio_mux port_e_gpio_mux_i (
    .*, .pkg_small(small_pkg), .pkg_largest(large_pkg), .mcu_mode(1'b1),
    .pwm_bc_pin_select(bc_sel), .pwm2_alt_pin_select(1'b0),
    .pwm1_out_b(pwm_v[0]), .pwm1_out_c(pwm_v[1]), .pwm3_out_b(pwm_v[2]),
    .pwm3_out_c(pwm_v[3]), .pwm2_out_a(pwm_v[4]), .pwm2_out_b(pwm_v[5]),
    .pwm2_out_c(pwm_v[6]), .pwm2_out_d(pwm_v[7]), .pwm1_enable(pwm_ctl[0]),
    .pwm2_enable(pwm_ctl[1]), .pwm3_enable(pwm_ctl[2]),
    .pwm_shutdown(pwm_ctl[3]));
  pad_model pad_model_i (.*);

  always #10 core_clk = ~core_clk;

  task automatic chk(input byte_t got, input byte_t exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input reg_addr_t a, input byte_t dat);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dat;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input reg_addr_t a, input byte_t exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(exp);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic settle;
    repeat (5) @(posedge core_clk);
  endtask : settle
  task automatic complete_run;
    // a read whose data never came back is a mismatch too
    if (exp_q.size() != 0) begin
      errors++;
    end
    if (errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // read data stands only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rd_seen) begin
      chk(reg_rdata, exp_q.pop_front());
    end
    rd_seen <= reg_rd;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h6068));
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    rd(4'h0, 8'hFF);
    rd(4'h3, 8'h00);
    wr(4'h4, 8'h80);
    d = byte_t'($urandom);
    v = byte_t'($urandom);
    pwm_v <= byte_t'($urandom);
    wr(4'h0, d);
    wr(4'h1, v);
    rd(4'h1, v);
    settle;
    chk(pad_oe, ~d);
    chk(pad_out & ~d, v & ~d);
    wr(4'h3, 8'hC0);
    settle;
    chk(pad_pullup, d);
    chk({7'h00, port_d_pullup_enable}, 8'h01);
    rd(4'h2, v | d);
    wr(4'h0, d | 8'h07);
    wr(4'h5, 8'h10);
    drv_en <= 8'h07;
    for (int k = 0; k < 8; k++) begin
      drv_val <= byte_t'(k);
      settle;
      chk({5'h00, slave_cs_b, slave_wr_b, slave_rd_b}, byte_t'(k));
    end
    chk({7'h00, slave_port_mode_bit}, 8'h01);
    pwm_ctl <= 4'h2;
    settle;
    chk({7'h00, pad_oe[0]}, 8'h01);
    chk({7'h00, pad_out[0]}, {7'h00, pwm_v[7]});
    chk({6'h00, pad_oe[7], pad_out[7]}, {6'h00, 1'b1, pwm_v[4]});
    chk({7'h00, pwm_bc_to_port_h}, 8'h00);
    wr(4'h6, 8'h01);
    pwm_ctl <= 4'hA;
    settle;
    chk({7'h00, pad_oe[0]}, 8'h00);
    pwm_ctl <= 4'h5;
    settle;
    chk({4'h0, pad_oe[6:3]}, 8'h0F);
    chk({4'h0, pad_out[3], pad_out[4], pad_out[5], pad_out[6]},
        {4'h0, pwm_v[3:0]});
    bc_sel <= 1'b0;
    settle;
    chk({7'h00, pwm_bc_to_port_h}, 8'h01);
    chk({4'h0, pad_oe[6:3]}, {4'h0, ~d[6:3]});
    pwm_ctl <= 4'h0;
    drv_en <= 8'h00;
    ext_bus_out <= byte_t'($urandom);
    ext_bus_oe <= 1'b1;
    wr(4'h4, 8'h00);
    settle;
    chk(pad_oe, 8'hFF);
    chk(pad_out, ext_bus_out);
    chk(ext_bus_in, ext_bus_out);
    // second reset, now as the small package without the bus
    rst_b <= 1'b0;
    small_pkg <= 1'b1;
    large_pkg <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(4'h0, 8'h3F);
    rd(4'h3, 8'h00);
    settle;
    complete_run;
  end
endmodule : tb_top
